/* File: hdl/dcsw_core.sv */
// drive command word decoder and state word assembler
module dcsw_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // holding register access from the bus front end
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRdValid,
  // configuration
  input wire logic [7:0] relay1Func,
  input wire logic [7:0] relay2Func,
  input wire logic [7:0] activeSetupSel,
  input wire dcsw_pkg::dcsw_rev_t revSource,
  input wire logic dinReverse,
  // drive state from the motor control
  input wire logic [15:0] actualFreq,
  input wire logic tripActive,
  input wire logic errorActive,
  input wire logic tripLocked,
  input wire logic warnActive,
  input wire logic atReference,
  input wire logic freqInLimits,
  input wire logic startPresent,
  input wire logic localBlock,
  input wire logic otAutoRestart,
  input wire logic dcLinkOut,
  input wire logic torqueOver,
  input wire logic timerOver,
  input wire logic linkLost,
  input wire logic dinStop,
  // drive commands
  output logic [1:0] presetSel,
  output logic dcBrake,
  output logic coast,
  output logic quickStop,
  output logic freqHold,
  output logic rampStop,
  output logic tripReset,
  output logic jogEn,
  output logic rampSet2,
  output logic relay1,
  output logic relay2,
  output logic [1:0] setupSel,
  output logic reverse,
  output logic [15:0] speedRef
);
  import dcsw_pkg::*;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] spd;
    logic [15:0] sta;
    logic [15:0] act;
    logic prevReset;
    logic [15:0] rdata;
    logic rdValid;
    logic [1:0] preset;
    logic dcBrake;
    logic coast;
    logic qStop;
    logic hold;
    logic rStop;
    logic tReset;
    logic jog;
    logic ramp2;
    logic rel1;
    logic rel2;
    logic [1:0] setup;
    logic rev;
  } dcsw_state_t;

  dcsw_state_t st_q;
  dcsw_state_t st_d;
  logic [15:0] cw;
  logic [15:0] staWord;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.tReset = 1'b0;
    // whole word taken in one cycle so every decoded bit changes together
    if (regWrite && regAddr == DCSW_REG_CMD) begin
      st_d.cmd = regWdata;
    end
    if (regWrite && regAddr == DCSW_REG_REF) begin
      st_d.spd = regWdata;
    end
    cw = st_q.cmd;
    // an invalid word leaves every command at its last accepted value, except trip reset (cleared) and reverse under DCSW_REV_DIN
    if (cw[CW_VALID]) begin
      st_d.preset = {cw[CW_PRESET_HI], cw[CW_PRESET_LO]};
      st_d.dcBrake = ~cw[CW_DCBRAKE_N];
      st_d.coast = ~cw[CW_COAST_N];
      st_d.hold = ~cw[CW_HOLD_N];
      // frozen output ignores ramp and quick stops
      st_d.qStop = ~cw[CW_QSTOP_N] & cw[CW_HOLD_N];
      st_d.rStop = ~cw[CW_START] & cw[CW_HOLD_N];
      st_d.tReset = cw[CW_RESET] & ~st_q.prevReset;
      st_d.prevReset = cw[CW_RESET];
      st_d.jog = cw[CW_JOG];
      st_d.ramp2 = cw[CW_RAMP2];
      st_d.rel1 = cw[CW_RELAY1] & (relay1Func == RELAY_FN_CW11);
      st_d.rel2 = cw[CW_RELAY2] & (relay2Func == RELAY_FN_CW12);
      if (activeSetupSel == SETUP_MULTI) begin
        st_d.setup = {cw[CW_SETUP_HI], cw[CW_SETUP_LO]};
      end
      unique case (revSource)
        DCSW_REV_DIN: st_d.rev = dinReverse;
        DCSW_REV_SERIAL: st_d.rev = cw[CW_REVERSE];
        DCSW_REV_OR: st_d.rev = cw[CW_REVERSE] | dinReverse;
        DCSW_REV_AND: st_d.rev = cw[CW_REVERSE] & dinReverse;
      endcase
    end else begin
      st_d.rev = (revSource == DCSW_REV_DIN) ? dinReverse : st_q.rev;
    end
    // state word assembly
    staWord = DCSW_WORD_ZERO;
    staWord[SW_CTRL_RDY] = ~tripActive;
    staWord[SW_DRV_RDY] = ~tripActive & (st_q.coast | dinStop);
    staWord[SW_ENABLE] = ~st_q.coast & ~st_q.dcBrake;
    staWord[SW_TRIP] = tripActive;
    staWord[SW_ERROR] = errorActive;
    staWord[SW_TRIPLOCK] = tripLocked;
    staWord[SW_WARN] = warnActive;
    staWord[SW_AT_REF] = atReference;
    staWord[SW_BUS_CTRL] = ~localBlock;
    staWord[SW_FLIM_OK] = freqInLimits;
    staWord[SW_IN_OP] = startPresent | (actualFreq != DCSW_WORD_ZERO);
    staWord[SW_OT_AUTO] = otAutoRestart;
    staWord[SW_VOLT] = dcLinkOut;
    staWord[SW_TORQUE] = torqueOver;
    staWord[SW_TIMER] = timerOver;
    st_d.sta = linkLost ? DCSW_WORD_ZERO : staWord;
    st_d.act = actualFreq;
    // read port: one cycle latency, unmapped numbers read as zero
    st_d.rdValid = regRead;
    st_d.rdata = DCSW_WORD_ZERO;
    if (regRead) begin
      unique case (regAddr)
        DCSW_REG_CMD: st_d.rdata = st_q.cmd;
        DCSW_REG_REF: st_d.rdata = st_q.spd;
        DCSW_REG_STA: st_d.rdata = st_q.sta;
        DCSW_REG_ACT: st_d.rdata = st_q.act;
        default: st_d.rdata = DCSW_WORD_ZERO;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign regRdValid = st_q.rdValid;
  assign presetSel = st_q.preset;
  assign dcBrake = st_q.dcBrake;
  assign coast = st_q.coast;
  assign quickStop = st_q.qStop;
  assign freqHold = st_q.hold;
  assign rampStop = st_q.rStop;
  assign tripReset = st_q.tReset;
  assign jogEn = st_q.jog;
  assign rampSet2 = st_q.ramp2;
  assign relay1 = st_q.rel1;
  assign relay2 = st_q.rel2;
  assign setupSel = st_q.setup;
  assign reverse = st_q.rev;
  assign speedRef = st_q.spd;

  // ************************************************************
  // checks
  // ************************************************************
  resetEdge_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tripReset |-> $past(st_q.cmd[CW_RESET]) && $past(st_q.cmd[CW_VALID])
      && !$past(st_q.prevReset))
    else $error("trip reset without rising edge");
  resetOnce_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tripReset |=> !tripReset)
    else $error("trip reset repeated");
  invalidHold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_q.cmd[CW_VALID] |=> $stable(coast) && $stable(presetSel) && $stable(jogEn))
    else $error("invalid word changed commands");
  coastMap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.cmd[CW_VALID] |=> coast == !$past(st_q.cmd[CW_COAST_N]))
    else $error("coast not following word");
  presetMap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.cmd[CW_VALID] |=> presetSel == $past(st_q.cmd[1:0]))
    else $error("preset select wrong");
  holdBlock_a: assert property (@(posedge core_clk) disable iff (!nrst)
    freqHold |-> !quickStop && !rampStop)
    else $error("ramp stop while frozen");
  relayGate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    relay1 |-> $past(relay1Func) == RELAY_FN_CW11)
    else $error("relay one without function");
  linkZero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    linkLost |=> st_q.sta == DCSW_WORD_ZERO)
    else $error("state word not cleared");
  cmdAtomic_a: assert property (@(posedge core_clk) disable iff (!nrst)
    regWrite && regAddr == DCSW_REG_CMD |=> st_q.cmd == $past(regWdata))
    else $error("command word not taken whole");
  brakeMap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.cmd[CW_VALID] |=> dcBrake == !$past(st_q.cmd[CW_DCBRAKE_N]))
    else $error("dc brake not following word");
  jogMap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.cmd[CW_VALID] |=> jogEn == $past(st_q.cmd[CW_JOG]))
    else $error("jog not following word");
  rampMap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.cmd[CW_VALID] |=> rampSet2 == $past(st_q.cmd[CW_RAMP2]))
    else $error("ramp set not following word");
  setupHold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    activeSetupSel != SETUP_MULTI |=> $stable(setupSel))
    else $error("set-up changed outside multi mode");
  readAnswer_a: assert property (@(posedge core_clk) disable iff (!nrst)
    regRead |=> regRdValid)
    else $error("read not answered");
endmodule

/* File: hdl/dcsw_pkg.sv */
// constants and field positions of the drive command/status word block
package dcsw_pkg;
  // holding register numbers seen by the master
  localparam logic [15:0] DCSW_REG_CMD = 16'hC350;  // 50000 decimal
  localparam logic [15:0] DCSW_REG_REF = 16'hC35A;  // 50010 decimal
  localparam logic [15:0] DCSW_REG_STA = 16'hC418;  // 50200 decimal
  localparam logic [15:0] DCSW_REG_ACT = 16'hC422;  // 50210 decimal
  // command word fields
  localparam int CW_PRESET_LO = 0;
  localparam int CW_PRESET_HI = 1;
  localparam int CW_DCBRAKE_N = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_QSTOP_N = 4;
  localparam int CW_HOLD_N = 5;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP2 = 9;
  localparam int CW_VALID = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY2 = 12;
  localparam int CW_SETUP_LO = 13;
  localparam int CW_SETUP_HI = 14;
  localparam int CW_REVERSE = 15;
  // state word fields
  localparam int SW_CTRL_RDY = 0;
  localparam int SW_DRV_RDY = 1;
  localparam int SW_ENABLE = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_ERROR = 4;
  localparam int SW_TRIPLOCK = 6;
  localparam int SW_WARN = 7;
  localparam int SW_AT_REF = 8;
  localparam int SW_BUS_CTRL = 9;
  localparam int SW_FLIM_OK = 10;
  localparam int SW_IN_OP = 11;
  localparam int SW_OT_AUTO = 12;
  localparam int SW_VOLT = 13;
  localparam int SW_TORQUE = 14;
  localparam int SW_TIMER = 15;
  // relay function codes and set-up mode code
  localparam logic [7:0] RELAY_FN_CW11 = 8'h24;  // 36
  localparam logic [7:0] RELAY_FN_CW12 = 8'h25;  // 37
  localparam logic [7:0] SETUP_MULTI = 8'h09;
  // reversing source selections
  typedef enum logic [1:0] {DCSW_REV_DIN, DCSW_REV_SERIAL, DCSW_REV_OR, DCSW_REV_AND} dcsw_rev_t;
  localparam logic [15:0] DCSW_WORD_ZERO = 16'h0000;
  localparam logic [15:0] DCSW_FULL_SCALE = 16'h4000;  // 100 percent
endpackage

/* File: sim/dcsw_master.sv */
// bus master model that writes and reads the holding registers
module dcsw_master (
  // clock
  input wire logic core_clk,
  // holding register port
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // bus cycles
  // ****************
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
  end
  // released lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [15:0] a, input logic [15:0] dat);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~dat;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] dat, output logic ok);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    ok = regRdValid;
    dat = regRdata;
  endtask
endmodule

/* File: sim/dcsw_core_tb.sv */
// self-checking bench of the drive command and state word block
module dcsw_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcsw_pkg::*;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
  // ****************
  // design and master
  // ****************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic regWrite, regRead, regRdValid, dinReverse, dcBrake, coast, quickStop, freqHold;
  logic rampStop, tripReset, jogEn, rampSet2, relay1, relay2, reverse, v;
  logic [15:0] regAddr, regWdata, regRdata, actualFreq, speedRef, d;
  logic [7:0] relay1Func, relay2Func, activeSetupSel;
  logic [1:0] presetSel, setupSel;
  logic [13:0] st;
  dcsw_rev_t revSource;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;
  wire logic [13:0] cmdOut = {presetSel, dcBrake, coast, quickStop, freqHold, rampStop, jogEn,
    rampSet2, relay1, relay2, setupSel, reverse};
  localparam logic [15:0] WORDS [8] = '{16'h047C, 16'h2D7D, 16'hD67E, 16'h0403, 16'h0423,
    16'h7B7F, 16'h9C6F, 16'h6400};
  localparam logic [13:0] PATS [4] = '{14'h0AAA, 14'h0555, 14'h1FFF, 14'h2000};
  always #25 core_clk = ~core_clk;
  dcsw_core i_dcsw_core (.*, .tripActive(st[0]), .errorActive(st[1]), .tripLocked(st[2]),
    .warnActive(st[3]), .atReference(st[4]), .freqInLimits(st[5]), .startPresent(st[6]),
    .localBlock(st[7]), .otAutoRestart(st[8]), .dcLinkOut(st[9]), .torqueOver(st[10]),
    .timerOver(st[11]), .linkLost(st[12]), .dinStop(st[13]));
  dcsw_master i_dcsw_master (.*);
  // ****************
  // expectations and scenarios
  // ****************
  function automatic logic [13:0] expCmd(input logic [15:0] w, input logic [1:0] oldSu);
    logic hold;
    hold = ~w[5];
    return {w[1:0], ~w[2], ~w[3], ~w[4] & ~hold, hold, ~w[6] & ~hold, w[8], w[9],
      w[11] & (relay1Func == RELAY_FN_CW11), w[12] & (relay2Func == RELAY_FN_CW12),
      (activeSetupSel == SETUP_MULTI) ? w[14:13] : oldSu,
      (revSource == DCSW_REV_DIN) ? dinReverse : w[15]};
  endfunction
  function automatic logic [15:0] expSta(input logic [13:0] s, input logic [15:0] w);
    logic [15:0] r;
    r = {s[11:8], s[6:5], ~s[7], s[4:2], 1'b0, s[1:0], w[3] & w[2],
      ~s[0] & (~w[3] | s[13]), ~s[0]};
    return s[12] ? DCSW_WORD_ZERO : r;
  endfunction
  task automatic t_cmd(input logic [7:0] f1, f2, sm, input dcsw_rev_t rs, input logic dr);
    logic [13:0] prev;
    logic [13:0] e;
    @(posedge core_clk);
    relay1Func <= f1;
    relay2Func <= f2;
    activeSetupSel <= sm;
    revSource <= rs;
    dinReverse <= dr;
    foreach (WORDS[i]) begin
      prev = cmdOut;
      i_dcsw_master.wr(DCSW_REG_CMD, WORDS[i]);
      @(posedge core_clk);
      #1;
      e = WORDS[i][10] ? expCmd(WORDS[i], prev[2:1]) : prev;
      `CHK("command", e, cmdOut)
    end
  endtask
  // a reset bit held across a repeated and an invalid word must not give a second pulse
  task automatic t_trip;
    int p0;
    p0 = pulses;
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0400);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0480);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0480);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0080);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0480);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0400);
    i_dcsw_master.wr(DCSW_REG_CMD, 16'h0480);
    repeat (3) @(posedge core_clk);
    `CHK("reset pulses", 2, pulses - p0)
  endtask
  task automatic t_state(input logic [15:0] w, input int n);
    i_dcsw_master.wr(DCSW_REG_CMD, w);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      st <= PATS[i];
      repeat (2) @(posedge core_clk);
      i_dcsw_master.rd(DCSW_REG_STA, d, v);
      `CHK("state word", expSta(PATS[i], w), d)
    end
  endtask
  task automatic t_regs;
    @(posedge core_clk);
    actualFreq <= DCSW_FULL_SCALE;
    i_dcsw_master.wr(DCSW_REG_REF, 16'hC000);
    i_dcsw_master.wr(DCSW_REG_ACT, 16'h1234);
    i_dcsw_master.wr(16'hC351, 16'h5555);
    i_dcsw_master.rd(DCSW_REG_CMD, d, v);
    `CHK("command readback", 16'h047C, d)
    i_dcsw_master.rd(DCSW_REG_REF, d, v);
    `CHK("read valid", 1'b1, v)
    `CHK("reference readback", 16'hC000, d)
    `CHK("speed reference", 16'hC000, speedRef)
    i_dcsw_master.rd(DCSW_REG_ACT, d, v);
    `CHK("actual value", DCSW_FULL_SCALE, d)
    i_dcsw_master.rd(16'hC351, d, v);
    `CHK("unmapped read", DCSW_WORD_ZERO, d)
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (tripReset === 1'b1) begin
      pulses++;
    end
    if (cycles == 3000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    dinReverse = 1'b0;
    relay1Func = 8'h00;
    relay2Func = 8'h00;
    activeSetupSel = 8'h00;
    revSource = DCSW_REV_DIN;
    actualFreq = 16'h0000;
    st = 14'h0000;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("reset outputs", 31'h0, {cmdOut, speedRef, regRdValid})
    t_cmd(RELAY_FN_CW11, RELAY_FN_CW12, SETUP_MULTI, DCSW_REV_SERIAL, 1'b0);
    t_cmd(RELAY_FN_CW12, RELAY_FN_CW11, 8'h08, DCSW_REV_DIN, 1'b1);
    t_cmd(RELAY_FN_CW11, 8'h00, SETUP_MULTI, DCSW_REV_OR, 1'b0);
    t_cmd(8'h00, RELAY_FN_CW12, 8'h00, DCSW_REV_AND, 1'b1);
    t_trip;
    t_state(16'h0480, 4);
    t_state(16'h047C, 3);
    t_regs;
    end_of_test;
  end
endmodule
